/* File: hw/irfu_core.sv */
// Purpose: Interrupt return sequencing and flag update for a 4-bit core
// Assumes: stack memory read is combinational on stk_addr
// Notes:   One instruction taken per enabled cycle when busy is low
// What this block does
// - Interrupt return: pre-increment pointer, then pop PC/flags
// - Interrupt return sets master interrupt enable
// - Add: carry from top result bit
// - Subtract: borrow from top bit, maybe inverted
// - Zero only when all four bits zero
// - Flags load selected source or keep
// - Zero flag follows value written to accumulator
// - L increment/decrement drives zero and status
// - Shift carry takes bit shifted out
// - Instruction sees next-instruction address as PC
// - Untaken branch sets status, goes next
`timescale 1ns/1ps
`default_nettype none
module irfu_core (
    input  wire logic                            clk,        // Core clock
    input  wire logic                            reset_n,    // Async reset, active low
    input  wire logic                            clk_en,     // Freezes all state except the reset release flops when low
    input  wire logic                            op_valid,   // Instruction presented
    input  wire irfu_pkg::irfu_op_t              op_code,    // Operation class
    input  wire irfu_pkg::irfu_fsel_t            cf_sel,     // Carry flag source
    input  wire irfu_pkg::irfu_fsel_t            zf_sel,     // Zero flag source
    input  wire irfu_pkg::irfu_fsel_t            sf_sel,     // Status flag source
    input  wire logic [irfu_pkg::DATA_W-1:0]     operand,    // Second ALU or load operand
    input  wire logic [irfu_pkg::PC_W-1:0]       target,     // Branch or call target
    input  wire logic [irfu_pkg::STK_W-1:0]      stk_rdata,  // Stack entry at stk_addr
    output logic [irfu_pkg::SP_W-1:0]            stk_addr,   // Stack pointer word
    output logic [irfu_pkg::STK_W-1:0]           stk_wdata,  // Entry to push
    output logic                                 stk_we,     // Stack write strobe
    output logic [irfu_pkg::PC_W-1:0]            pc,         // Program counter
    output logic [irfu_pkg::DATA_W-1:0]          acc,        // Accumulator register
    output logic [irfu_pkg::DATA_W-1:0]          lreg,       // L pointer register
    output logic                                 carry_flag, // Carry flag
    output logic                                 zero_flag,  // Zero flag
    output logic                                 status_flag,// Status flag
    output logic                                 int_enable, // Interrupt master enable
    output logic                                 busy        // Return pop in progress
);
    // ==========================================================
    // Reset release
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ==========================================================
    // State
    typedef struct packed {
        irfu_pkg::irfu_state_t              st;
        logic [irfu_pkg::PC_W-1:0]          pc;
        logic [irfu_pkg::SP_W-1:0]          sp;
        logic [irfu_pkg::FLAG_W-1:0]        flags;
        logic [irfu_pkg::DATA_W-1:0]        acc;
        logic [irfu_pkg::DATA_W-1:0]        lreg;
        logic                               ime;
        logic [irfu_pkg::STK_W-1:0]         wdata;
        logic                               we;
    } irfu_core_state_t;

    irfu_core_state_t s_r;
    irfu_core_state_t s_nxt;

    function automatic logic pick_flag(input irfu_pkg::irfu_fsel_t sel, input logic old_v,
                                       input logic c, input logic b, input logic z);
        unique case (sel)
            irfu_pkg::IRFU_FS_KEEP: pick_flag = old_v;
            irfu_pkg::IRFU_FS_C:    pick_flag = c;
            irfu_pkg::IRFU_FS_NC:   pick_flag = ~c;
            irfu_pkg::IRFU_FS_NB:   pick_flag = ~b;
            irfu_pkg::IRFU_FS_Z:    pick_flag = z;
            irfu_pkg::IRFU_FS_NZ:   pick_flag = ~z;
            irfu_pkg::IRFU_FS_ONE:  pick_flag = 1'b1;
            irfu_pkg::IRFU_FS_ZERO: pick_flag = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic [irfu_pkg::DATA_W:0]   wide;
        logic [irfu_pkg::DATA_W-1:0] res;
        logic [irfu_pkg::PC_W-1:0]   pc_next;
        logic                        cy;
        logic                        bw;
        logic                        zd;
        logic                        wr_acc;
        logic                        wr_l;
        logic                        upd;
        wide    = '0;
        res     = '0;
        zd      = 1'b0;
        cy      = 1'b0;
        bw      = 1'b0;
        wr_acc  = 1'b0;
        wr_l    = 1'b0;
        upd     = 1'b0;
        s_nxt   = s_r;
        s_nxt.we = 1'b0;
        pc_next = s_r.pc + irfu_pkg::PC_STEP;
        unique case (op_code)
            irfu_pkg::IRFU_OP_ADD: begin
                wide   = {1'b0, s_r.acc} + {1'b0, operand};
                res    = wide[irfu_pkg::DATA_W-1:0];
                cy     = wide[irfu_pkg::DATA_W];
                wr_acc = 1'b1;
            end
            irfu_pkg::IRFU_OP_SUB: begin
                wide   = {1'b0, s_r.acc} - {1'b0, operand};
                res    = wide[irfu_pkg::DATA_W-1:0];
                bw     = wide[irfu_pkg::DATA_W];
                cy     = bw;
                wr_acc = 1'b1;
            end
            irfu_pkg::IRFU_OP_LOAD: begin
                res    = operand;
                wr_acc = 1'b1;
            end
            irfu_pkg::IRFU_OP_INCL: begin
                wide = {1'b0, s_r.lreg} + {1'b0, irfu_pkg::D_ONE};
                res  = wide[irfu_pkg::DATA_W-1:0];
                cy   = wide[irfu_pkg::DATA_W];
                wr_l = 1'b1;
            end
            irfu_pkg::IRFU_OP_DECL: begin
                wide = {1'b0, s_r.lreg} - {1'b0, irfu_pkg::D_ONE};
                res  = wide[irfu_pkg::DATA_W-1:0];
                cy   = wide[irfu_pkg::DATA_W];
                bw   = cy;
                wr_l = 1'b1;
            end
            irfu_pkg::IRFU_OP_SHL: begin
                res    = {s_r.acc[irfu_pkg::DATA_W-2:0], 1'b0};
                cy     = s_r.acc[irfu_pkg::DATA_W-1];
                wr_acc = 1'b1;
            end
            irfu_pkg::IRFU_OP_SHR: begin
                res    = {1'b0, s_r.acc[irfu_pkg::DATA_W-1:1]};
                cy     = s_r.acc[0];
                wr_acc = 1'b1;
            end
            default: begin
                res = s_r.acc;
            end
        endcase
        zd = (res == '0);

        if (s_r.st == irfu_pkg::IRFU_ST_POP) begin
            // Entry at the incremented pointer is read now
            s_nxt.pc    = stk_rdata[irfu_pkg::STK_PC_LSB +: irfu_pkg::PC_W];
            s_nxt.flags = stk_rdata[irfu_pkg::STK_FLAG_LSB +: irfu_pkg::FLAG_W];
            s_nxt.ime   = 1'b1;
            s_nxt.st    = irfu_pkg::IRFU_ST_RUN;
        end else if (op_valid) begin
            upd = 1'b1;
            s_nxt.pc = pc_next;
            unique case (op_code)
                irfu_pkg::IRFU_OP_RETURN_FROM_INTERRUPT: begin
                    // Pointer moves first so the pop reads the new entry
                    s_nxt.sp = s_r.sp + irfu_pkg::SP_STEP;
                    s_nxt.st = irfu_pkg::IRFU_ST_POP;
                    upd      = 1'b0;
                end
                irfu_pkg::IRFU_OP_BRANCH: begin
                    upd = 1'b0;
                    if (s_r.flags[irfu_pkg::FLAG_SF]) begin
                        s_nxt.pc = target;
                    end else begin
                        s_nxt.flags[irfu_pkg::FLAG_SF] = 1'b1;
                    end
                end
                irfu_pkg::IRFU_OP_CALL: begin
                    upd         = 1'b0;
                    s_nxt.wdata = {s_r.flags, pc_next};
                    s_nxt.we    = 1'b1;
                    s_nxt.sp    = s_r.sp - irfu_pkg::SP_STEP;
                    s_nxt.pc    = target;
                end
                irfu_pkg::IRFU_OP_NOP: begin
                    upd = 1'b0;
                end
                default: begin
                    if (wr_acc) begin
                        s_nxt.acc = res;
                    end
                    if (wr_l) begin
                        s_nxt.lreg = res;
                    end
                end
            endcase
            if (upd) begin
                s_nxt.flags[irfu_pkg::FLAG_CF] = pick_flag(cf_sel, s_r.flags[irfu_pkg::FLAG_CF], cy, bw, zd);
                s_nxt.flags[irfu_pkg::FLAG_ZF] = pick_flag(zf_sel, s_r.flags[irfu_pkg::FLAG_ZF], cy, bw, zd);
                s_nxt.flags[irfu_pkg::FLAG_SF] = pick_flag(sf_sel, s_r.flags[irfu_pkg::FLAG_SF], cy, bw, zd);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r.st    <= irfu_pkg::IRFU_ST_RUN;
            s_r.pc    <= irfu_pkg::PC_RST;
            s_r.sp    <= irfu_pkg::SP_RST;
            s_r.flags <= irfu_pkg::FLAG_RST;
            s_r.acc   <= irfu_pkg::ACC_RST;
            s_r.lreg  <= irfu_pkg::LREG_RST;
            s_r.ime   <= irfu_pkg::IME_RST;
            s_r.wdata <= '0;
            s_r.we    <= 1'b0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs straight from state
    assign stk_addr    = s_r.sp;
    assign stk_wdata   = s_r.wdata;
    assign stk_we      = s_r.we;
    assign pc          = s_r.pc;
    assign acc         = s_r.acc;
    assign lreg        = s_r.lreg;
    assign carry_flag  = s_r.flags[irfu_pkg::FLAG_CF];
    assign zero_flag   = s_r.flags[irfu_pkg::FLAG_ZF];
    assign status_flag = s_r.flags[irfu_pkg::FLAG_SF];
    assign int_enable  = s_r.ime;
    assign busy        = (s_r.st == irfu_pkg::IRFU_ST_POP);
endmodule // irfu_core
`default_nettype wire

/* File: shared/irfu_pkg.sv */
// Purpose: Constants and types for the return and flag update unit
// Assumes: 4-bit data path, 12-bit program counter, 4-bit stack pointer word
// Notes:   Opcodes of the operation select port are local to this unit
package irfu_pkg;
    localparam int unsigned DATA_W  = 4;
    localparam int unsigned PC_W    = 12;
    localparam int unsigned SP_W    = 4;
    localparam int unsigned FLAG_W  = 3;
    // Stack entry: flags above the program counter
    localparam int unsigned STK_W   = FLAG_W + PC_W;
    localparam int unsigned STK_PC_LSB   = 0;
    localparam int unsigned STK_FLAG_LSB = PC_W;
    // Flag positions within a flag word
    localparam int unsigned FLAG_CF = 2;
    localparam int unsigned FLAG_ZF = 1;
    localparam int unsigned FLAG_SF = 0;
    // Reset values, then step constants
    localparam logic [PC_W-1:0]   PC_RST   = 12'h000;
    localparam logic [SP_W-1:0]   SP_RST   = 4'hF;
    localparam logic [FLAG_W-1:0] FLAG_RST = 3'h1;
    localparam logic [DATA_W-1:0] ACC_RST  = 4'h0;
    localparam logic [DATA_W-1:0] LREG_RST = 4'h0;
    localparam logic              IME_RST  = 1'b0;
    localparam logic [PC_W-1:0]   PC_STEP  = 12'h001;
    localparam logic [SP_W-1:0]   SP_STEP  = 4'h1;
    localparam logic [DATA_W-1:0] D_ONE    = 4'h1;

    // Operation classes presented by the decoder
    typedef enum logic [3:0] {
        IRFU_OP_NOP    = 4'h0,
        IRFU_OP_RETURN_FROM_INTERRUPT   = 4'h1,
        IRFU_OP_ADD    = 4'h2,
        IRFU_OP_SUB    = 4'h3,
        IRFU_OP_LOAD   = 4'h4,
        IRFU_OP_INCL   = 4'h5,
        IRFU_OP_DECL   = 4'h6,
        IRFU_OP_SHL    = 4'h7,
        IRFU_OP_SHR    = 4'h8,
        IRFU_OP_BRANCH = 4'h9,
        IRFU_OP_CALL   = 4'hA
    } irfu_op_t;

    // Source loaded into one flag
    typedef enum logic [2:0] {
        IRFU_FS_KEEP  = 3'h0,
        IRFU_FS_C     = 3'h1,
        IRFU_FS_NC    = 3'h2,
        IRFU_FS_NB    = 3'h3,
        IRFU_FS_Z     = 3'h4,
        IRFU_FS_NZ    = 3'h5,
        IRFU_FS_ONE   = 3'h6,
        IRFU_FS_ZERO  = 3'h7
    } irfu_fsel_t;

    typedef enum logic [1:0] {
        IRFU_ST_RUN  = 2'b00,
        IRFU_ST_POP  = 2'b01
    } irfu_state_t;
endpackage

/* File: bench/irfu_core_monitor.sv */
// Purpose: Assertions on the interrupt return and flag update unit
// Assumes: op_valid stays low until the reset synchroniser has released
// Notes:   Attached to irfu_core by the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module irfu_core_monitor (
    input wire logic                 clk,         // Clock
    input wire logic                 reset_n,     // Reset
    input wire logic                 clk_en,      // Enable
    input wire logic                 op_valid,    // Request
    input wire irfu_pkg::irfu_op_t   op_code,     // Class
    input wire irfu_pkg::irfu_fsel_t cf_sel,      // Carry source
    input wire irfu_pkg::irfu_fsel_t zf_sel,      // Zero source
    input wire irfu_pkg::irfu_fsel_t sf_sel,      // Status source
    input wire logic [3:0]           operand,     // Operand
    input wire logic [11:0]          target,      // Target
    input wire logic [14:0]          stk_rdata,   // Popped entry
    input wire logic [3:0]           stk_addr,    // Pointer
    input wire logic [14:0]          stk_wdata,   // Pushed entry
    input wire logic                 stk_we,      // Push strobe
    input wire logic [11:0]          pc,          // Program counter
    input wire logic [3:0]           acc,         // Accumulator
    input wire logic [3:0]           lreg,        // L register
    input wire logic                 carry_flag,  // Carry
    input wire logic                 zero_flag,   // Zero
    input wire logic                 status_flag, // Status
    input wire logic                 int_enable,  // Master enable
    input wire logic                 busy         // Pop in progress
);
    wire logic [3:0] oc = op_code;
    wire logic [2:0] cs = cf_sel;
    wire logic [2:0] zs = zf_sel;
    wire logic       tk = clk_en && op_valid && !busy;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========
    // Checks
    chk_return_from_interrupt_pop: assert property (tk && oc == 4'h1 |=> busy && stk_addr == $past(stk_addr) + 4'h1)
        else $error("pointer not advanced before pop");
    chk_return_from_interrupt_load: assert property (busy && clk_en |=>
        !busy && int_enable && {carry_flag, zero_flag, status_flag, pc} == $past(stk_rdata)) else $error("bad pop");
    chk_add_carry: assert property (tk && oc == 4'h2 && cs == 3'h1 |=>
        carry_flag == ({1'b0, $past(acc)} + {1'b0, $past(operand)} > 5'h0F)) else $error("add carry wrong");
    chk_zero_acc: assert property (tk && oc inside {4'h2, 4'h3, 4'h4} && zs == 3'h4 |=> zero_flag == (acc == 4'h0))
        else $error("zero flag not from accumulator");
    chk_lreg_zero: assert property (tk && oc inside {4'h5, 4'h6} && zs == 3'h4 |=> zero_flag == (lreg == 4'h0))
        else $error("zero flag not from L");
    chk_call_push: assert property (tk && oc == 4'hA |=>
        stk_we && stk_wdata[11:0] == $past(pc) + 12'h001 && pc == $past(target) ##1 (!stk_we || !$past(clk_en)))
        else $error("bad push");
    chk_branch_skip: assert property (tk && oc == 4'h9 && !status_flag |=> status_flag && pc == $past(pc) + 12'h001)
        else $error("untaken branch wrong");
    chk_nop_quiet: assert property (tk && oc == 4'h0 |=>
        pc == $past(pc) + 12'h001 && $stable({acc, lreg, carry_flag, zero_flag, status_flag})) else $error("nop changed state");
    cover property (tk && oc == 4'h1);
    cover property (tk && oc == 4'hA);
    cover property (tk && oc == 4'h9 && !status_flag);
endmodule // irfu_core_monitor
bind irfu_core irfu_core_monitor u_mon (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .cf_sel(cf_sel), .zf_sel(zf_sel), .sf_sel(sf_sel), .operand(operand), .target(target),
    .stk_rdata(stk_rdata), .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_we(stk_we), .pc(pc), .acc(acc),
    .lreg(lreg), .carry_flag(carry_flag), .zero_flag(zero_flag), .status_flag(status_flag),
    .int_enable(int_enable), .busy(busy));
`default_nettype wire

/* File: bench/irfu_core_tb.sv */
// Purpose: Self-checking bench for the interrupt return and flag update unit
// Assumes: stack memory lives here and is written at stk_addr+1
// Notes:   Directed table first, then fixed-seed random operations
`timescale 1ns/1ps
`default_nettype none
module irfu_core_tb;
    logic clk, reset_n, clk_en, op_valid, stk_we, carry_flag, zero_flag, status_flag, int_enable, busy;
    logic e_c, e_z, e_s, e_ie;
    logic [2:0] cs, zs, ss;
    logic [3:0] op, operand, stk_addr, acc, lreg, e_acc, e_l, e_sp, o4;
    logic [11:0] target, pc, e_pc;
    logic [14:0] stk_rdata, stk_wdata, mem [16], em [16];
    logic [31:0] rnd;
    int n_fail, n_checks;
    localparam logic [19:0] dir_ops [15] = '{20'h40400, 20'h2146F, 20'h21461, 20'h33511, 20'h31471, 20'h90000,
        20'h90000, 20'h51410, 20'h61410, 20'h61410, 20'h71400, 20'h82500, 20'h07770, 20'hA0000, 20'h10000};
    irfu_core dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .op_valid(op_valid),
        .op_code(irfu_pkg::irfu_op_t'(op)), .cf_sel(irfu_pkg::irfu_fsel_t'(cs)),
        .zf_sel(irfu_pkg::irfu_fsel_t'(zs)), .sf_sel(irfu_pkg::irfu_fsel_t'(ss)), .operand(operand),
        .target(target), .stk_rdata(stk_rdata), .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_we(stk_we),
        .pc(pc), .acc(acc), .lreg(lreg), .carry_flag(carry_flag), .zero_flag(zero_flag),
        .status_flag(status_flag), .int_enable(int_enable), .busy(busy));
    assign stk_rdata = mem[stk_addr];
    always @(posedge clk) if (stk_we === 1'b1) mem[stk_addr + 4'h1] <= stk_wdata;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic fs(input logic [2:0] sel, input logic old, input logic cy, input logic z);
        case (sel)
            3'h0: return old;
            3'h1: return cy;
            3'h2, 3'h3: return ~cy;
            3'h4: return z;
            3'h5: return ~z;
            default: return sel == 3'h6;
        endcase
    endfunction
    // Carry sources are only meaningful where an arithmetic carry exists
    function automatic logic [2:0] san(input logic [3:0] o, input logic [2:0] s);
        if (s == 3'h3 && o != 4'h3) return 3'h2;
        if (o == 4'h4 && s inside {3'h1, 3'h2}) return 3'h0;
        return s;
    endfunction
    task automatic chk(input logic [28:0] got, input logic [28:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t state %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic exe(input logic [19:0] w);
        logic [4:0] r;
        logic cy, zz;
        int k;
        rnd = lfsr(rnd);
        @(negedge clk);
        {op, cs, zs, ss, operand, target} = {w[19:16], w[14:12], w[10:8], w[6:4], w[3:0], rnd[27:16]};
        op_valid = 1'b1;
        clk_en = rnd[5];
        if (!rnd[5]) begin
            @(negedge clk);
            clk_en = 1'b1;
        end
        @(posedge clk);
        cy = 1'b0;
        case (op)
            4'h2: r = {1'b0, e_acc} + {1'b0, operand};
            4'h3: r = {1'b0, e_acc} - {1'b0, operand};
            4'h4: r = {1'b0, operand};
            4'h5: {cy, e_l} = {1'b0, e_l} + 5'h01;
            4'h6: {cy, e_l} = {1'b0, e_l} - 5'h01;
            4'h7: r = {e_acc, 1'b0};
            4'h8: r = {e_acc[0], 1'b0, e_acc[3:1]};
            default: r = {1'b0, e_acc};
        endcase
        zz = (op == 4'h5 || op == 4'h6) ? e_l == 4'h0 : r[3:0] == 4'h0;
        if (op >= 4'h2 && op <= 4'h8) begin
            cy = (op == 4'h5 || op == 4'h6) ? cy : r[4];
            e_acc = (op == 4'h5 || op == 4'h6) ? e_acc : r[3:0];
            {e_c, e_z, e_s} = {fs(cs, e_c, cy, zz), fs(zs, e_z, cy, zz), fs(ss, e_s, cy, zz)};
        end
        e_pc = e_pc + 12'h001;
        if (op == 4'h9 && !e_s) e_s = 1'b1;
        else if (op == 4'h9) e_pc = target;
        if (op == 4'hA) begin
            em[e_sp] = {e_c, e_z, e_s, e_pc};
            e_sp = e_sp - 4'h1;
            e_pc = target;
        end
        if (op == 4'h1) begin
            e_sp = e_sp + 4'h1;
            {e_c, e_z, e_s, e_pc} = em[e_sp];
            e_ie = 1'b1;
        end
        @(negedge clk);
        op_valid = 1'b0;
        // Freeze one cycle at random, also in the middle of a return pop
        clk_en = rnd[6];
        @(negedge clk);
        clk_en = 1'b1;
        for (k = 0; k < 8 && busy !== 1'b0; k++) @(negedge clk);
        if (k == 8) begin
            n_fail++;
            conclude();
        end
        chk({pc, acc, lreg, carry_flag, zero_flag, status_flag, int_enable, stk_addr, busy},
            {e_pc, e_acc, e_l, e_c, e_z, e_s, e_ie, e_sp, 1'b0});
    endtask
    // ==========
    // Sequence
    initial begin
        {clk_en, op_valid, op, cs, zs, ss, operand, target} = '0;
        {reset_n, n_fail, n_checks, rnd} = {1'b0, 64'h0, 32'h00018379};
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            mem[i] = rnd[14:0];
            em[i] = rnd[14:0];
        end
        {e_pc, e_acc, e_l, e_c, e_z, e_s, e_ie, e_sp} = {12'h000, 8'h00, 4'h2, 4'hF};
        repeat (5) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({pc, acc, lreg, carry_flag, zero_flag, status_flag, int_enable, stk_addr, busy},
            {e_pc, e_acc, e_l, e_c, e_z, e_s, e_ie, e_sp, 1'b0});
        $display("test reset done");
        foreach (dir_ops[i]) exe(dir_ops[i]);
        $display("test directed done");
        repeat (300) begin
            o4 = 4'(rnd[7:0] % 8'h0B);
            exe({o4, 1'b0, san(o4, rnd[10:8]), 1'b0, san(o4, rnd[14:12]), 1'b0, san(o4, rnd[18:16]), rnd[23:20]});
        end
        $display("test random done");
        conclude();
    end
endmodule // irfu_core_tb
`default_nettype wire
